/* verilog/srb_pkg.sv */
// Shared constants and types of the serial receiver and baud generator
package srb_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [2:0] OFF_RCS = 3'h0;
  localparam logic [2:0] OFF_BAUD = 3'h1;
  localparam logic [2:0] OFF_DIV_LO = 3'h2;
  localparam logic [2:0] OFF_DIV_HI = 3'h3;
  localparam logic [2:0] OFF_TCS = 3'h4;
  localparam logic [2:0] OFF_RXBUF = 3'h5;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int RCS_PORT_EN = 7;
  localparam int RCS_RX9 = 6;
  localparam int RCS_SINGLE_RECEIVE_ENABLE = 5;
  localparam int RCS_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int RCS_ADDRESS_DETECT_ENABLE = 3;
  localparam int RCS_FRAMING_ERROR_FLAG = 2;
  localparam int RCS_OVERRUN_ERROR_FLAG = 1;
  localparam int RCS_NINTH = 0;
  localparam int BAUD_ROLL = 7;
  localparam int BAUD_IDLE = 6;
  localparam int BAUD_POL = 4;
  localparam int BAUD_WIDE = 3;
  localparam int BAUD_WUE = 1;
  localparam int BAUD_AUTOBAUD_ENABLE = 0;
  localparam int TCS_MASTER = 7;
  localparam int TCS_SYNC = 4;
  localparam int TCS_HIGH_RATE_SELECT = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [7:0] RXBUF_RESET = 8'h00;
  localparam logic IDLE_RESET = 1'b1;

  // ****************************************
  // Timing
  // ****************************************
  // Ticks per bit as a power of two: 64, 16, 4
  localparam logic [2:0] LOG_TPB_SLOW = 3'h6;
  localparam logic [2:0] LOG_TPB_MID = 3'h4;
  localparam logic [2:0] LOG_TPB_FAST = 3'h2;
  // Measured span of the sync field is eight bits
  localparam logic [4:0] ABD_SPAN_LOG = 5'h3;
  localparam logic [2:0] ABD_LAST_EDGE = 3'h4;
  localparam int ABD_CNT_W = 26;
  // Synchronous clock: two ticks per half period
  localparam logic SYNC_HALF_LAST = 1'b1;
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b010,
    ST_STOP = 3'b011,
    ST_SYNC = 3'b100,
    ST_ABD = 3'b101
  } srb_state_e;

endpackage

/* verilog/srb_baud_gen.sv */
// Free-running baud timer with 8- or 16-bit reload
module srb_baud_gen #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic restart,
  input wire logic wide,
  input wire logic [DIV_W-1:0] divisor,
  // Rate
  output logic tick
);
  localparam int BYTE_W = 8;

  logic [DIV_W-1:0] count_reg;
  logic tick_reg;
  wire logic [DIV_W-1:0] limit;
  wire logic wrap;

  // Narrow mode ignores the high byte
  assign limit = wide ? divisor : {{(DIV_W-BYTE_W){1'b0}}, divisor[BYTE_W-1:0]};
  assign wrap = (count_reg >= limit);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
      tick_reg <= 1'b0;
    end else if (restart || !run) begin
      count_reg <= '0;
      tick_reg <= 1'b0;
    end else if (wrap) begin
      count_reg <= '0;
      tick_reg <= 1'b1;
    end else begin
      count_reg <= count_reg + 1'b1;
      tick_reg <= 1'b0;
    end
  end

  assign tick = tick_reg;

endmodule

/* verilog/srb_receiver.sv */
// Serial receiver control, status and baud generation
// How it works
// - Port enable low holds port in reset; high makes pins serial pins.
// - Ninth-bit enable picks 9-bit or 8-bit reception.
// - Single receive takes one word as sync master, then self-clears.
// - Continuous enable runs async receiver; in sync it outranks single.
// - Address detect drops 9-bit async words with ninth bit clear.
// - Framing error flag changes only when a word is loaded or the port is disabled.
// - Overrun flag sets on overrun, clears when continuous enable clears.
// - Received ninth bit is readable; parity is firmware's job.
// - Rollover during auto-baud sets a flag only software clears.
// - Idle flag reads one when no reception runs; resets to one.
// - Clock polarity sets the sync clock idle level.
// - Wide select uses both divisor bytes, else only low byte.
// - Wake-up flags a falling edge, self-clears on next rising edge.
// - Auto-baud measures the 55h field, then clears its enable.
// - Unimplemented baud control bits read zero.
// - Baud timer free-runs with period from the divisor pair.
// - Sync mode ignores high rate select.
// - Bit time is divisor plus one times 64, 16 or 4 clocks.
// - Divisor writes restart the baud timer at once.
// - Receive level is a three-sample majority vote.
// - High rate select in transmit control applies to async only.
//
// The register offsets and the plain strobed port were decided locally.
module srb_receiver (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [srb_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [srb_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [srb_pkg::DATA_W-1:0] reg_rdata,
  // Pins
  input wire logic receive_data_pin_in,
  input wire logic transmit_clock_pin_in,
  output logic transmit_clock_pin_out,
  output logic transmit_clock_pin_oe,
  // Events
  output logic rx_word_ready,
  output logic wakeup_pulse
);
  import srb_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic port_en_reg, rx9_reg, single_receive_enable_reg, continuous_receive_enable_reg, address_detect_enable_reg;
  logic framing_error_flag_reg, overrun_error_flag_reg, ninth_reg;
  logic rollover_reg, polarity_reg, wide_reg, wue_reg, autobaud_enable_reg;
  logic master_reg, sync_reg, high_rate_select_reg;
  logic [7:0] div_lo_reg, div_hi_reg, rxbuf_reg, rdata_reg;
  logic buf_full_reg, rx_idle_reg, wake_pulse_reg, ck_oe_reg, wake_seen_reg;
  logic rx_meta_reg, rx_sync_reg, rx_vote_reg, rx_prev_reg;
  logic [1:0] rx_hist_reg;
  logic ck_meta_reg, ck_sync_reg, ck_prev_reg;
  srb_state_e state_reg, state_next;
  logic [6:0] tick_cnt_reg, tick_cnt_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [8:0] shift_reg, shift_next;
  logic half_cnt_reg, half_cnt_next;
  logic ck_out_reg, ck_out_next;
  logic [ABD_CNT_W-1:0] abd_cnt_reg, abd_cnt_next;
  logic [2:0] edge_cnt_reg, edge_cnt_next;
  logic done, done_framing_error_flag, abd_finish, abd_over;

  wire logic wr_rcs, wr_baud, wr_lo, wr_hi, wr_tcs, rd_buf;
  wire logic async_en, async_go, sync_go, abd_go;
  wire logic rx_fall, rx_rise, ck_edge, brg_tick, sync_sample;
  wire logic wake_arm, wake_fall, wake_rise;
  wire logic [2:0] log_tpb;
  wire logic [6:0] tpb_last, half_last;
  wire logic [3:0] last_bit;
  wire logic [4:0] abd_shift, abd_top;
  wire logic [15:0] abd_div;
  wire logic [8:0] word9;
  wire logic accept, load, overrun, single_receive_enable_clr;
  wire logic [7:0] rcs_rd, baud_rd, tcs_rd, rd_mux;

  // ****************************************
  // Decode and mode selection
  // ****************************************
  assign wr_rcs = reg_wr && (reg_addr == OFF_RCS);
  assign wr_baud = reg_wr && (reg_addr == OFF_BAUD);
  assign wr_lo = reg_wr && (reg_addr == OFF_DIV_LO);
  assign wr_hi = reg_wr && (reg_addr == OFF_DIV_HI);
  assign wr_tcs = reg_wr && (reg_addr == OFF_TCS);
  assign rd_buf = reg_rd && (reg_addr == OFF_RXBUF);

  assign async_en = port_en_reg && !sync_reg;
  assign async_go = async_en && continuous_receive_enable_reg && !overrun_error_flag_reg && !wue_reg && !autobaud_enable_reg;
  // Continuous enable alone, or single enable only as master
  assign sync_go = port_en_reg && sync_reg && !overrun_error_flag_reg
                   && (continuous_receive_enable_reg || (single_receive_enable_reg && master_reg));
  assign abd_go = async_en && autobaud_enable_reg && !wue_reg;

  // High rate select only matters in async mode
  assign log_tpb = (wide_reg && high_rate_select_reg) ? LOG_TPB_FAST :
                   (!wide_reg && !high_rate_select_reg) ? LOG_TPB_SLOW : LOG_TPB_MID;
  assign tpb_last = 7'((7'h01 << log_tpb) - 7'h01);
  assign half_last = 7'((7'h01 << (log_tpb - 3'h1)) - 7'h01);
  assign last_bit = rx9_reg ? LAST_BIT_9 : LAST_BIT_8;
  assign abd_shift = 5'(log_tpb) + ABD_SPAN_LOG;
  assign abd_top = abd_shift + 5'h10;
  assign abd_div = 16'((abd_cnt_reg >> abd_shift) - 26'h1);

  assign rx_fall = rx_prev_reg && !rx_vote_reg;
  assign rx_rise = !rx_prev_reg && rx_vote_reg;
  assign ck_edge = ck_sync_reg != ck_prev_reg;
  // Sample on the clock edge that returns to idle
  assign sync_sample = (state_reg == ST_SYNC) && (master_reg
                       ? (brg_tick && half_cnt_reg == SYNC_HALF_LAST
                          && ck_out_reg != polarity_reg)
                       : (ck_edge && ck_sync_reg == polarity_reg));

  assign wake_arm = async_en && wue_reg;
  assign wake_fall = wake_arm && !wake_seen_reg && rx_fall;
  assign wake_rise = wake_arm && wake_seen_reg && rx_rise;

  assign word9 = rx9_reg ? shift_next : {1'b0, shift_next[8:1]};
  assign accept = done && !(rx9_reg && address_detect_enable_reg && !sync_reg && !word9[8]);
  assign load = accept && (!buf_full_reg || rd_buf);
  assign overrun = accept && !load;
  assign single_receive_enable_clr = done && sync_reg && !continuous_receive_enable_reg;

  // ****************************************
  // Baud timer
  // ****************************************
  srb_baud_gen #(
    .DIV_W(16)
  ) u_baud (
    .clk(clk),
    .rst(rst),
    .run(port_en_reg),
    .restart(wr_lo || wr_hi || abd_finish),
    .wide(wide_reg),
    .divisor({div_hi_reg, div_lo_reg}),
    .tick(brg_tick)
  );

  // ****************************************
  // Pin synchronisers and majority vote
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_hist_reg <= 2'h3;
      rx_vote_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
      ck_meta_reg <= 1'b0;
      ck_sync_reg <= 1'b0;
      ck_prev_reg <= 1'b0;
    end else begin
      rx_meta_reg <= receive_data_pin_in;
      rx_sync_reg <= rx_meta_reg;
      rx_hist_reg <= {rx_hist_reg[0], rx_sync_reg};
      rx_vote_reg <= (rx_sync_reg & rx_hist_reg[0]) | (rx_sync_reg & rx_hist_reg[1])
                     | (rx_hist_reg[0] & rx_hist_reg[1]);
      rx_prev_reg <= rx_vote_reg;
      ck_meta_reg <= transmit_clock_pin_in;
      ck_sync_reg <= ck_meta_reg;
      ck_prev_reg <= ck_sync_reg;
    end
  end

  // ****************************************
  // Receive state machine
  // ****************************************
  always_comb begin
    state_next = state_reg;
    tick_cnt_next = tick_cnt_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    half_cnt_next = half_cnt_reg;
    ck_out_next = ck_out_reg;
    abd_cnt_next = abd_cnt_reg;
    edge_cnt_next = edge_cnt_reg;
    done = 1'b0;
    done_framing_error_flag = 1'b0;
    abd_finish = 1'b0;
    abd_over = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        tick_cnt_next = 7'h00;
        bit_cnt_next = 4'h0;
        half_cnt_next = 1'b0;
        ck_out_next = polarity_reg;
        abd_cnt_next = '0;
        edge_cnt_next = 3'h0;
        if (abd_go) begin
          state_next = ST_ABD;
        end else if (async_go && rx_fall) begin
          state_next = ST_START;
        end else if (sync_go) begin
          state_next = ST_SYNC;
        end
      end
      ST_START: begin
        if (brg_tick) begin
          if (tick_cnt_reg == half_last) begin
            tick_cnt_next = 7'h00;
            // A start that is gone by mid-bit was a glitch
            state_next = rx_vote_reg ? ST_IDLE : ST_DATA;
          end else begin
            tick_cnt_next = tick_cnt_reg + 7'h01;
          end
        end
      end
      ST_DATA: begin
        if (brg_tick) begin
          if (tick_cnt_reg == tpb_last) begin
            tick_cnt_next = 7'h00;
            shift_next = {rx_vote_reg, shift_reg[8:1]};
            bit_cnt_next = bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == last_bit) begin
              state_next = ST_STOP;
            end
          end else begin
            tick_cnt_next = tick_cnt_reg + 7'h01;
          end
        end
      end
      ST_STOP: begin
        if (brg_tick) begin
          if (tick_cnt_reg == tpb_last) begin
            done = 1'b1;
            done_framing_error_flag = !rx_vote_reg;
            state_next = ST_IDLE;
          end else begin
            tick_cnt_next = tick_cnt_reg + 7'h01;
          end
        end
      end
      ST_SYNC: begin
        if (!sync_go) begin
          state_next = ST_IDLE;
          ck_out_next = polarity_reg;
        end else begin
          if (master_reg && brg_tick) begin
            half_cnt_next = !half_cnt_reg;
            if (half_cnt_reg == SYNC_HALF_LAST) begin
              ck_out_next = !ck_out_reg;
            end
          end
          if (sync_sample) begin
            shift_next = {rx_vote_reg, shift_reg[8:1]};
            bit_cnt_next = bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == last_bit) begin
              done = 1'b1;
              bit_cnt_next = 4'h0;
              if (!continuous_receive_enable_reg) begin
                state_next = ST_IDLE;
              end
            end
          end
        end
      end
      ST_ABD: begin
        if (!abd_go) begin
          state_next = ST_IDLE;
        end else if (abd_cnt_reg[abd_top]) begin
          abd_over = 1'b1;
          state_next = ST_IDLE;
        end else begin
          if (edge_cnt_reg != 3'h0) begin
            abd_cnt_next = abd_cnt_reg + 1'b1;
          end
          // Fifth falling edge of 55h closes eight bit times
          if (rx_fall) begin
            if (edge_cnt_reg == ABD_LAST_EDGE) begin
              abd_finish = 1'b1;
              state_next = ST_IDLE;
            end else begin
              edge_cnt_next = edge_cnt_reg + 3'h1;
            end
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (!port_en_reg) begin
      state_next = ST_IDLE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      tick_cnt_reg <= 7'h00;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 9'h000;
      half_cnt_reg <= 1'b0;
      ck_out_reg <= 1'b0;
      abd_cnt_reg <= '0;
      edge_cnt_reg <= 3'h0;
      rx_idle_reg <= IDLE_RESET;
    end else begin
      state_reg <= state_next;
      tick_cnt_reg <= tick_cnt_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      half_cnt_reg <= half_cnt_next;
      ck_out_reg <= ck_out_next;
      abd_cnt_reg <= abd_cnt_next;
      edge_cnt_reg <= edge_cnt_next;
      rx_idle_reg <= (state_next == ST_IDLE);
    end
  end

  // ****************************************
  // Receive control and status
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {port_en_reg, rx9_reg, single_receive_enable_reg, continuous_receive_enable_reg, address_detect_enable_reg} <= 5'h00;
    end else if (wr_rcs) begin
      port_en_reg <= reg_wdata[RCS_PORT_EN];
      rx9_reg <= reg_wdata[RCS_RX9];
      single_receive_enable_reg <= reg_wdata[RCS_SINGLE_RECEIVE_ENABLE];
      continuous_receive_enable_reg <= reg_wdata[RCS_CONTINUOUS_RECEIVE_ENABLE];
      address_detect_enable_reg <= reg_wdata[RCS_ADDRESS_DETECT_ENABLE];
    end else if (single_receive_enable_clr) begin
      single_receive_enable_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      framing_error_flag_reg <= 1'b0;
      ninth_reg <= 1'b0;
      overrun_error_flag_reg <= 1'b0;
      rxbuf_reg <= RXBUF_RESET;
      buf_full_reg <= 1'b0;
    end else begin
      if (!port_en_reg) begin
        framing_error_flag_reg <= 1'b0;
      end else if (load) begin
        framing_error_flag_reg <= done_framing_error_flag;
        ninth_reg <= word9[8];
        rxbuf_reg <= word9[7:0];
      end
      if (overrun) begin
        overrun_error_flag_reg <= 1'b1;
      end else if (!port_en_reg || (wr_rcs && !reg_wdata[RCS_CONTINUOUS_RECEIVE_ENABLE])) begin
        overrun_error_flag_reg <= 1'b0;
      end
      if (load) begin
        buf_full_reg <= 1'b1;
      end else if (rd_buf || !port_en_reg) begin
        buf_full_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Baud control, mode and divisor
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {rollover_reg, polarity_reg, wide_reg, wue_reg, autobaud_enable_reg} <= 5'h00;
      {master_reg, sync_reg, high_rate_select_reg} <= 3'h0;
    end else begin
      if (abd_over) begin
        rollover_reg <= 1'b1;
      end else if (wr_baud && !reg_wdata[BAUD_ROLL]) begin
        rollover_reg <= 1'b0;
      end
      if (wr_baud) begin
        polarity_reg <= reg_wdata[BAUD_POL];
        wide_reg <= reg_wdata[BAUD_WIDE];
        wue_reg <= reg_wdata[BAUD_WUE];
        autobaud_enable_reg <= reg_wdata[BAUD_AUTOBAUD_ENABLE];
      end else begin
        if (wake_rise) begin
          wue_reg <= 1'b0;
        end
        if (abd_finish || abd_over) begin
          autobaud_enable_reg <= 1'b0;
        end
      end
      if (wr_tcs) begin
        master_reg <= reg_wdata[TCS_MASTER];
        sync_reg <= reg_wdata[TCS_SYNC];
        high_rate_select_reg <= reg_wdata[TCS_HIGH_RATE_SELECT];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_lo_reg <= DIV_RESET;
      div_hi_reg <= DIV_RESET;
    end else if (abd_finish) begin
      div_lo_reg <= abd_div[7:0];
      div_hi_reg <= abd_div[15:8];
    end else begin
      if (wr_lo) begin
        div_lo_reg <= reg_wdata;
      end
      if (wr_hi) begin
        div_hi_reg <= reg_wdata;
      end
    end
  end

  // ****************************************
  // Wake-up, pins and read data
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_seen_reg <= 1'b0;
      wake_pulse_reg <= 1'b0;
      ck_oe_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      wake_seen_reg <= wake_arm && (wake_seen_reg ? !wake_rise : wake_fall);
      wake_pulse_reg <= wake_fall;
      ck_oe_reg <= port_en_reg && sync_reg && master_reg;
      rdata_reg <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign rcs_rd = {port_en_reg, rx9_reg, single_receive_enable_reg, continuous_receive_enable_reg, address_detect_enable_reg,
                   framing_error_flag_reg, overrun_error_flag_reg, ninth_reg};
  assign baud_rd = {rollover_reg, rx_idle_reg, 1'b0, polarity_reg, wide_reg,
                    1'b0, wue_reg, autobaud_enable_reg};
  assign tcs_rd = {master_reg, 2'h0, sync_reg, 1'b0, high_rate_select_reg, 2'h0};
  assign rd_mux = (reg_addr == OFF_RCS) ? rcs_rd :
                  (reg_addr == OFF_BAUD) ? baud_rd :
                  (reg_addr == OFF_DIV_LO) ? div_lo_reg :
                  (reg_addr == OFF_DIV_HI) ? div_hi_reg :
                  (reg_addr == OFF_TCS) ? tcs_rd :
                  (reg_addr == OFF_RXBUF) ? rxbuf_reg : 8'h00;

  assign reg_rdata = rdata_reg;
  assign transmit_clock_pin_out = ck_out_reg;
  assign transmit_clock_pin_oe = ck_oe_reg;
  assign rx_word_ready = buf_full_reg;
  assign wakeup_pulse = wake_pulse_reg;

endmodule

/* test/srb_remote_tx.sv */
// Behavioural remote serial transmitter on the receive data line
module srb_remote_tx (
  // Serial line
  output logic line,
  // Clock from the synchronous master
  input wire logic sclk
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Frame sender
  // ****************************************
  initial line = 1'b1;

  // Start bit, n data bits LSB first, stop bit, one idle bit
  task automatic send(input logic [9:0] bits, input int n, input int per,
                      input logic stp);
    #2;
    line = 1'b0;
    #(per * 8);
    for (int i = 0; i < n; i++) begin
      line = bits[i];
      #(per * 8);
    end
    line = stp;
    #(per * 8);
    line = 1'b1;
    #(per * 8);
  endtask

  // Sync peer: next bit just after each clock edge that leaves idle low
  task automatic sync_send(input logic [8:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sclk);
      #1;
      line = bits[i];
    end
  endtask
endmodule

/* test/srb_receiver_properties.sv */
// Port-level checks of the serial receiver
module srb_receiver_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [srb_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [srb_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [srb_pkg::DATA_W-1:0] reg_rdata,
  // Pins and events
  input wire logic receive_data_pin_in,
  input wire logic rx_word_ready,
  input wire logic wakeup_pulse
);
  import srb_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ****************************************
  // Properties
  // ****************************************
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  unmapped_read_a: assert property (reg_rd && reg_addr[2:1] == 2'b11 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  baud_unused_a: assert property (
    reg_rd && reg_addr == OFF_BAUD |=> reg_rdata[5] == 1'b0 && reg_rdata[2] == 1'b0)
    else $error("unused baud control bits not zero");
  wake_single_a: assert property (wakeup_pulse |=> !wakeup_pulse)
    else $error("wake pulse longer than one cycle");
  wake_cause_a: assert property (wakeup_pulse |->
    !$past(receive_data_pin_in, 3) || !$past(receive_data_pin_in, 4) ||
    !$past(receive_data_pin_in, 5) || !$past(receive_data_pin_in, 6))
    else $error("wake pulse without low line");
  ready_hold_a: assert property (rx_word_ready &&
    !(reg_rd && reg_addr == OFF_RXBUF) && !(reg_wr && reg_addr == OFF_RCS) |=> rx_word_ready)
    else $error("word ready lost without read");
  div_readback_a: assert property (
    reg_wr && reg_addr == OFF_DIV_LO ##2 reg_rd && reg_addr == OFF_DIV_LO
    |=> reg_rdata == $past(reg_wdata, 3))
    else $error("divisor low readback wrong");
  rcs_readback_a: assert property (
    reg_wr && reg_addr == OFF_RCS ##2 reg_rd && reg_addr == OFF_RCS
    |=> reg_rdata[7:3] == $past(reg_wdata[7:3], 3))
    else $error("receive control readback wrong");
endmodule

bind srb_receiver srb_receiver_checker chk_i (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .receive_data_pin_in(receive_data_pin_in), .rx_word_ready(rx_word_ready),
  .wakeup_pulse(wakeup_pulse));

/* test/srb_receiver_test.sv */
// Directed testbench of the serial receiver
module srb_receiver_test;
  timeunit 1ns;
  timeprecision 1ps;
  import srb_pkg::*;
  logic clk;
  logic rst;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic rxd;
  logic ck_out;
  logic ck_oe;
  logic rx_word_ready;
  logic wakeup_pulse;
  logic [7:0] q;
  int n_errors;
  int checked;

  srb_remote_tx remote (.line(rxd), .sclk(ck_out));
  srb_receiver uut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .receive_data_pin_in(rxd),
    .transmit_clock_pin_in(ck_out), .transmit_clock_pin_out(ck_out),
    .transmit_clock_pin_oe(ck_oe), .rx_word_ready(rx_word_ready),
    .wakeup_pulse(wakeup_pulse));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    q = reg_rdata;
    chk(q, e);
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    for (int i = 0; i < 8; i++) begin
      rdc(3'(i), (i == 1) ? 8'h40 : 8'h00);
    end
    wr(OFF_BAUD, 8'h3C);
    rdc(OFF_BAUD, 8'h58);
    wr(OFF_BAUD, 8'h00);
    $display("test reset and baud control done");
  endtask
  task automatic t_async;
    wr(OFF_TCS, 8'h04);
    wr(OFF_DIV_HI, 8'h05);
    wr(OFF_RCS, 8'h90);
    rdc(OFF_RCS, 8'h90);
    fork
      remote.send(10'h0A5, 8, 16, 1'b1);
      begin
        repeat (40) @(posedge clk);
        rdc(OFF_BAUD, 8'h00);
      end
    join
    chk(8'(rx_word_ready), 8'h01);
    rdc(OFF_RCS, 8'h90);
    rdc(OFF_RXBUF, 8'hA5);
    chk(8'(rx_word_ready), 8'h00);
    remote.send(10'h03C, 8, 16, 1'b0);
    rdc(OFF_RCS, 8'h94);
    rdc(OFF_RXBUF, 8'h3C);
    remote.send(10'h011, 8, 16, 1'b1);
    rdc(OFF_RCS, 8'h90);
    rdc(OFF_RXBUF, 8'h11);
    $display("test async and framing done");
  endtask
  task automatic t_over;
    remote.send(10'h001, 8, 16, 1'b1);
    remote.send(10'h002, 8, 16, 1'b1);
    rdc(OFF_RCS, 8'h92);
    wr(OFF_RCS, 8'h80);
    rdc(OFF_RCS, 8'h80);
    rdc(OFF_RXBUF, 8'h01);
    wr(OFF_RCS, 8'hD8);
    remote.send(10'h033, 9, 16, 1'b1);
    chk(8'(rx_word_ready), 8'h00);
    remote.send(10'h144, 9, 16, 1'b1);
    chk(8'(rx_word_ready), 8'h01);
    rdc(OFF_RCS, 8'hD9);
    rdc(OFF_RXBUF, 8'h44);
    wr(OFF_RCS, 8'h90);
    $display("test overrun and address detect done");
  endtask
  task automatic t_wide;
    wr(OFF_BAUD, 8'h08);
    wr(OFF_DIV_HI, 8'h00);
    wr(OFF_DIV_LO, 8'h01);
    rdc(OFF_DIV_LO, 8'h01);
    remote.send(10'h05A, 8, 8, 1'b1);
    rdc(OFF_RXBUF, 8'h5A);
    wr(OFF_BAUD, 8'h00);
    wr(OFF_DIV_LO, 8'h00);
    $display("test wide divisor done");
  endtask
  task automatic t_wake;
    logic seen;
    seen = 1'b0;
    wr(OFF_BAUD, 8'h02);
    fork
      remote.send(10'h000, 8, 16, 1'b1);
      for (int i = 0; i < 100; i++) begin
        @(posedge clk);
        if (wakeup_pulse === 1'b1) seen = 1'b1;
      end
    join
    chk(8'(seen), 8'h01);
    rdc(OFF_BAUD, 8'h40);
    wr(OFF_BAUD, 8'h01);
    remote.send(10'h055, 8, 72, 1'b1);
    rdc(OFF_BAUD, 8'h40);
    rdc(OFF_DIV_LO, 8'h03);
    wr(OFF_DIV_LO, 8'h00);
    $display("test wake-up and auto-baud done");
  endtask
  task automatic t_sync;
    wr(OFF_RCS, 8'h00);
    wr(OFF_TCS, 8'h90);
    wr(OFF_BAUD, 8'h10);
    wr(OFF_RCS, 8'h80);
    settle();
    chk(8'({ck_oe, ck_out}), 8'h03);
    wr(OFF_BAUD, 8'h00);
    settle();
    chk(8'({ck_oe, ck_out}), 8'h02);
    wr(OFF_RCS, 8'h00);
    settle();
    chk(8'(ck_oe), 8'h00);
    wr(OFF_DIV_LO, 8'h03);
    fork
      remote.sync_send(9'h0C3, 8);
      wr(OFF_RCS, 8'hA0);
    join
    repeat (12) @(posedge clk);
    chk(8'(rx_word_ready), 8'h01);
    rdc(OFF_RCS, 8'h80);
    rdc(OFF_RXBUF, 8'hC3);
    chk(8'({ck_oe, ck_out}), 8'h02);
    $display("test sync clock pin and single receive done");
  endtask

  initial begin
    rst = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_async();
    t_over();
    t_wide();
    t_wake();
    t_sync();
    report_and_stop();
  end

  initial begin
    #400000;
    n_errors++;
    report_and_stop();
  end
endmodule
